// ---- shared/fast_ethernet_rx_pkg.sv ----
package fast_ethernet_rx_pkg;
    typedef enum logic [3:0] {
        ST_HUNT = 4'b0001,
        ST_SSD = 4'b0010,
        ST_FRAME = 4'b0100,
        ST_END = 4'b1000
    } rx_state_t;
    typedef logic [1:0] mlt3_level_t;
endpackage

// ---- shared/fast_ethernet_rx_regs.svh ----
`ifndef FAST_ETHERNET_RX_REGS_SVH
`define FAST_ETHERNET_RX_REGS_SVH
// ****************************************************************
// register map (index = word, byte address = index * 4)
// ****************************************************************
`define STAT_REG_INDEX 6'd30
`define CFG_REG_INDEX 6'd31
`define CFG_DESCR_BYPASS_BIT 0
`define CFG_DECODE_EN_BIT 6
`define CFG_RESET 32'h0000_0040
// ****************************************************************
// code-groups and fixed nibbles
// ****************************************************************
`define CG_IDLE 5'h1f
`define CG_J 5'h18
`define CG_K 5'h11
`define CG_T 5'h0d
`define CG_R 5'h07
`define NIB_PREAMBLE 4'h5
`define NIB_BAD_SSD 4'he
// ****************************************************************
// timing
// ****************************************************************
`define CLOCK_PERIOD_NS 4
`define IDLE_WINDOW_NS 40000
`define IDLE_RUN_BITS 4'd10
`define LOCK_MATCH_BITS 6'd40
`define MII_DIV 4'd10
`define MII_FALL 4'd5
`define RMII_DIV 3'd5
`define RMII_FALL 3'd3
`define NUM_PHASES 4
`endif

// ---- testbench/fast_ethernet_rx_pcs_tb_top.sv ----
`timescale 1ns/1ps
`include "fast_ethernet_rx_regs.svh"
module fast_ethernet_rx_pcs_tb_top;
    import fast_ethernet_rx_pkg::*;
    logic i_clock = 1'h0;
    logic i_reset_n = 1'h0;
    logic [7:0] i_avs_address = 8'h0;
    logic i_avs_read = 1'h0;
    logic i_avs_write = 1'h0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic i_rmii_strap = 1'h0;
    logic i_bit_strobe = 1'h0;
    logic [7:0] i_phase_level = 8'h0;
    logic [15:0] i_phase_quality = 16'h3c33;
    logic i_signal_present = 1'h1;
    logic i_link_fail = 1'h0;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest, o_rx_clk, o_ref_clk, o_rx_dv, o_rx_er, o_crs;
    logic [3:0] o_rxd;
    int fails = 0;
    int num_checks = 0;
    int bp = 2;
    logic [10:0] key = 11'h5a5;
    logic nrzi = 1'h0;
    logic scr = 1'h0;
    logic [1:0] m = 2'h0;
    logic [31:0] q;
    logic [4:0] tx[$];
    logic [3:0] want[$];
    localparam logic [4:0] cg_data [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
        5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    localparam logic [4:0] cg_bad [11] = '{5'h04, 5'h06, 5'h19, 5'h00, 5'h01, 5'h02,
        5'h03, 5'h05, 5'h08, 5'h0c, 5'h10};
    always #2 i_clock = ~i_clock;
    // short window keeps the abort test brief
    fast_ethernet_rx_pcs #(.IDLE_WINDOW_CYCLES(400)) i_fast_ethernet_rx_pcs (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_rmii_strap(i_rmii_strap), .i_bit_strobe(i_bit_strobe), .i_phase_level(i_phase_level),
        .i_phase_quality(i_phase_quality), .i_signal_present(i_signal_present),
        .i_link_fail(i_link_fail), .o_rx_clk(o_rx_clk), .o_ref_clk(o_ref_clk), .o_rxd(o_rxd),
        .o_rx_dv(o_rx_dv), .o_rx_er(o_rx_er), .o_crs(o_crs));
    mac_rx_model i_mac_rx_model (.i_clock(i_clock), .i_rmii(i_rmii_strap), .i_rx_clk(o_rx_clk),
        .i_ref_clk(o_ref_clk), .i_rxd(o_rxd), .i_rx_dv(o_rx_dv), .i_rx_er(o_rx_er));
    // ******************************
    // bus, line and compare tasks
    // ******************************
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_avs_waitrequest !== 1'h0 && n < 40);
        q = o_avs_readdata;
        if (n >= 40) fails++;
        i_avs_write <= 1'h0;
        i_avs_read <= 1'h0;
    endtask
    // scramble, nrzi, then mlt-3; weaker phases carry a wrong level
    task automatic send_bit(input logic b);
        logic s;
        logic [1:0] lvl;
        logic [7:0] v;
        s = b ^ (scr & (key[10] ^ key[8]));
        key = {key[9:0], key[10] ^ key[8]};
        nrzi = nrzi ^ s;
        m = m + {1'h0, nrzi};
        lvl = m[0] ? {m[1], 1'h1} : 2'h0;
        v = {4{(lvl == 2'h0) ? 2'h1 : 2'h0}};
        v[2*bp+:2] = lvl;
        @(posedge i_clock);
        i_phase_level <= v;
        i_bit_strobe <= 1'h1;
        @(posedge i_clock);
        i_bit_strobe <= 1'h0;
    endtask
    task automatic send_cg(input logic [4:0] cg);
        for (int i = 4; i >= 0; i--) send_bit(cg[i]);
    endtask
    task automatic start();
        repeat (4) send_cg(`CG_IDLE);
        send_cg(`CG_J);
        send_cg(`CG_K);
        foreach (tx[i]) send_cg(tx[i]);
    endtask
    task automatic finish(input logic tr);
        send_cg(tr ? `CG_T : `CG_IDLE);
        send_cg(tr ? `CG_R : `CG_IDLE);
        repeat (6) send_cg(`CG_IDLE);
    endtask
    task automatic load_all();
        tx.delete();
        want = '{4'h5, 4'h5};
        for (int i = 0; i < 16; i++) begin
            tx.push_back(cg_data[i]);
            want.push_back(i[3:0]);
        end
    endtask
    task automatic chk_nibs();
        check("nibble count", want.size(), i_mac_rx_model.nibs.size());
        foreach (want[i]) check("nibble", want[i], i_mac_rx_model.nibs[i]);
        i_mac_rx_model.nibs.delete();
    endtask
    // ******************************
    // tests
    // ******************************
    initial begin
        repeat (40000) @(posedge i_clock);
        fails++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge i_clock);
        i_reset_n <= 1'h1;
        repeat (2) @(posedge i_clock);
        bus(1'h0, 8'h7c, 32'h0);
        check("cfg reset", 32'h0000_0040, q);
        bus(1'h1, 8'h7c, 32'hffff_ffff);
        bus(1'h0, 8'h7c, 32'h0);
        check("cfg bits", 32'h0000_0041, q);
        bus(1'h1, 8'h40, 32'hffff_ffff);
        bus(1'h0, 8'h40, 32'h0);
        check("unmapped", 32'h0, q);
        bus(1'h0, 8'h78, 32'h0);
        check("mii mode", 1'h0, q[6]);
        $display("test registers done");
        load_all();
        start();
        finish(1'h1);
        chk_nibs();
        check("errors", 32'h0, i_mac_rx_model.er_cnt);
        check("valid after end", 1'h0, o_rx_dv);
        check("carrier after end", 1'h0, o_crs);
        check("launch", 32'h0, i_mac_rx_model.late);
        $display("test mii frame done");
        foreach (cg_bad[k]) begin
            tx = '{cg_data[7], cg_bad[k], cg_data[7]};
            i_mac_rx_model.er_cnt = 0;
            start();
            finish(1'h0);
            check("error seen", 1'h1, i_mac_rx_model.er_cnt > 0);
            check("valid dropped", 1'h0, o_rx_dv);
            check("first data", 4'h7, i_mac_rx_model.nibs[2]);
            i_mac_rx_model.nibs.delete();
        end
        $display("test invalid groups done");
        repeat (4) send_cg(`CG_IDLE);
        send_cg(`CG_J);
        repeat (2) send_cg(cg_data[7]);
        repeat (6) send_cg(`CG_IDLE);
        check("bad start", 1'h1, i_mac_rx_model.bad_ssd > 0);
        check("no data", 32'h0, i_mac_rx_model.nibs.size());
        $display("test bad start done");
        for (int k = 0; k < 2; k++) begin
            tx = '{cg_data[1], cg_data[2]};
            start();
            check("valid in frame", 1'h1, o_rx_dv);
            check("carrier in frame", 1'h1, o_crs);
            if (k == 0) i_signal_present <= 1'h0;
            else i_link_fail <= 1'h1;
            repeat (3) send_cg(cg_data[3]);
            check("valid on loss", 1'h0, o_rx_dv);
            i_signal_present <= 1'h1;
            i_link_fail <= 1'h0;
            finish(1'h1);
            i_mac_rx_model.nibs.delete();
        end
        $display("test signal loss done");
        bus(1'h1, 8'h7c, 32'h0000_0001);
        tx = '{5'h1e, 5'h09};
        want = '{4'h5, 4'h5, 4'he, 4'h9};
        i_mac_rx_model.er_cnt = 0;
        start();
        finish(1'h1);
        chk_nibs();
        check("fifth bit", 1'h1, i_mac_rx_model.er_cnt > 0);
        $display("test decoder bypass done");
        bp = 1;
        i_phase_quality <= 16'h33c3;
        scr = 1'h1;
        bus(1'h1, 8'h7c, 32'h0000_0040);
        repeat (20) send_cg(`CG_IDLE);
        bus(1'h0, 8'h78, 32'h0);
        check("locked", 1'h1, q[7]);
        load_all();
        start();
        finish(1'h1);
        chk_nibs();
        tx.delete();
        repeat (50) tx.push_back(cg_data[3]);
        start();
        check("abort valid", 1'h0, o_rx_dv);
        bus(1'h0, 8'h78, 32'h0);
        check("resync", 1'h0, q[7]);
        finish(1'h1);
        i_mac_rx_model.nibs.delete();
        $display("test scrambled done");
        // mac side never asks for decoder bypass in rmii
        i_reset_n <= 1'h0;
        i_rmii_strap <= 1'h1;
        repeat (6) @(posedge i_clock);
        i_reset_n <= 1'h1;
        scr = 1'h0;
        repeat (2) @(posedge i_clock);
        bus(1'h1, 8'h7c, 32'h0000_0041);
        bus(1'h0, 8'h78, 32'h0);
        check("rmii mode", 1'h1, q[6]);
        load_all();
        start();
        finish(1'h1);
        chk_nibs();
        $display("test rmii done");
        summarize();
    end
endmodule // fast_ethernet_rx_pcs_tb_top

// ---- testbench/mac_rx_model.sv ----
`timescale 1ns/1ps
// ******************************
// mac receive side, sampling only
// ******************************
module mac_rx_model (
    input wire logic i_clock,
    input wire logic i_rmii,
    input wire logic i_rx_clk,
    input wire logic i_ref_clk,
    input wire logic [3:0] i_rxd,
    input wire logic i_rx_dv,
    input wire logic i_rx_er
);
    logic [3:0] nibs[$];
    int er_cnt = 0;
    int bad_ssd = 0;
    int late = 0;
    logic hi = 1'h0;
    logic [1:0] lo_r = 2'h0;
    logic [3:0] rxd_r = 4'h0;
    logic clk_r = 1'h0;
    // rising edge only, so pins launched on the falling edge are settled
    always @(posedge i_rx_clk) begin
        if (i_rx_dv) begin
            nibs.push_back(i_rxd);
        end
        if (i_rx_er && i_rx_dv) begin
            er_cnt++;
        end
        if (i_rx_er && !i_rx_dv && i_rxd == 4'he) begin
            bad_ssd++;
        end
    end
    // low pair arrives first
    always @(posedge i_ref_clk) begin
        if (!i_rx_dv) begin
            hi <= 1'h0;
        end else if (!hi) begin
            lo_r <= i_rxd[1:0];
            hi <= 1'h1;
        end else begin
            nibs.push_back({i_rxd[1:0], lo_r});
            hi <= 1'h0;
        end
    end
    // mii pins may only move where the receive clock falls
    always @(posedge i_clock) begin
        if (!i_rmii && i_rxd !== rxd_r && !(clk_r && !i_rx_clk)) begin
            late++;
        end
        rxd_r <= i_rxd;
        clk_r <= i_rx_clk;
    end
endmodule // mac_rx_model

// ---- verilog/fast_ethernet_rx_pcs.sv ----
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "fast_ethernet_rx_regs.svh"
// Function
// - pick best sampling phase as recovered clock
// - turn three-level line values into NRZI
// - MLT-3 level change means one
// - descramble and deserialise the stream
// - sync key on idles, then hold it
// - no idles in window: abort, resync
// - config bit 0 bypasses the descrambler
// - align code-groups on J K, keep
// - control code-group encodings, invalid raises error
// - translate groups, J K give 0101 twice
// - data-valid rises with first preamble nibble
// - T R or two idles end frame
// - link fail or no signal drops data-valid
// - config bit 6 clear bypasses decoder
// - decoder bypass only in MII mode
// - unexpected group in frame raises error
// - bad start pair: error, 1110, no valid
// - MII nibbles launched on falling edge
// - MII clock recovered, else free-running
// - RMII pairs launched on falling edge
module fast_ethernet_rx_pcs
    import fast_ethernet_rx_pkg::*;
#(
    parameter int IDLE_WINDOW_CYCLES = `IDLE_WINDOW_NS / `CLOCK_PERIOD_NS
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_rmii_strap,
    input wire logic i_bit_strobe,
    input wire logic [2*`NUM_PHASES-1:0] i_phase_level,
    input wire logic [4*`NUM_PHASES-1:0] i_phase_quality,
    input wire logic i_signal_present,
    input wire logic i_link_fail,
    output logic o_rx_clk,
    output logic o_ref_clk,
    output logic [3:0] o_rxd,
    output logic o_rx_dv,
    output logic o_rx_er,
    output logic o_crs
);
    // ****************************************************************
    // register bus
    // ****************************************************************
    logic ack_r;
    logic [31:0] cfg_r;
    logic rmii_mode_r;
    logic strap_done_r;
    logic locked_r;
    rx_state_t state_r;
    logic access;
    logic hit_cfg;
    logic hit_stat;
    logic descr_bypass;
    logic dec_bypass;

    assign access = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = access & ~ack_r;
    assign hit_cfg = (i_avs_address[7:2] == `CFG_REG_INDEX) && (i_avs_address[1:0] == 2'h0);
    assign hit_stat = (i_avs_address[7:2] == `STAT_REG_INDEX) && (i_avs_address[1:0] == 2'h0);
    assign descr_bypass = cfg_r[`CFG_DESCR_BYPASS_BIT];
    assign dec_bypass = ~cfg_r[`CFG_DECODE_EN_BIT] & ~rmii_mode_r;

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ack_r <= 1'b0;
            o_avs_readdata <= 32'h0;
        end else begin
            ack_r <= access & ~ack_r;
            if (i_avs_read && !ack_r) begin
                if (hit_cfg) begin
                    o_avs_readdata <= cfg_r;
                end else if (hit_stat) begin
                    o_avs_readdata <= {24'h0, locked_r, rmii_mode_r, 2'h0, state_r};
                end else begin
                    o_avs_readdata <= 32'h0;
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_r <= `CFG_RESET;
        end else if (i_avs_write && ack_r && hit_cfg) begin
            cfg_r <= i_avs_writedata & 32'h0000_0041;
        end
    end

    // strap is caught after reset release, not by the reset itself
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strap_done_r <= 1'b0;
            rmii_mode_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            rmii_mode_r <= i_rmii_strap;
        end
    end

    // ****************************************************************
    // phase selection and line decoding
    // ****************************************************************
    mlt3_level_t lvl [`NUM_PHASES];
    logic [3:0] qual [`NUM_PHASES];
    logic [1:0] best;
    logic [1:0] sel_r;
    mlt3_level_t lvl_prev_r;
    logic nrzi_lvl_r;
    logic nrzi_old_r;
    logic s1_vld_r;
    logic nrzi_bit;

    genvar gp;
    generate
        for (gp = 0; gp < `NUM_PHASES; gp++) begin : g_phase
            assign lvl[gp] = i_phase_level[2*gp +: 2];
            assign qual[gp] = i_phase_quality[4*gp +: 4];
        end
    endgenerate

    always_comb begin
        best = 2'h0;
        for (int p = 1; p < `NUM_PHASES; p++) begin
            if (qual[p] > qual[best]) begin
                best = 2'(p);
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sel_r <= 2'h0;
            lvl_prev_r <= 2'h0;
            nrzi_lvl_r <= 1'b0;
            nrzi_old_r <= 1'b0;
            s1_vld_r <= 1'b0;
        end else begin
            s1_vld_r <= i_bit_strobe;
            if (i_bit_strobe) begin
                sel_r <= best;
                lvl_prev_r <= lvl[sel_r];
                nrzi_lvl_r <= (lvl[sel_r] != lvl_prev_r);
                nrzi_old_r <= nrzi_lvl_r;
            end
        end
    end
    assign nrzi_bit = nrzi_lvl_r ^ nrzi_old_r;

    // ****************************************************************
    // descrambler and idle window
    // ****************************************************************
    logic [10:0] key_r;
    logic [5:0] match_cnt_r;
    logic [3:0] ones_cnt_r;
    logic [13:0] win_cnt_r;
    logic key_pred;
    logic plain;
    logic plain_vld;
    logic timeout;

    assign key_pred = key_r[10] ^ key_r[8];
    assign plain = descr_bypass ? nrzi_bit : (nrzi_bit ^ key_pred);
    assign plain_vld = s1_vld_r & (locked_r | descr_bypass);
    assign timeout = locked_r && (win_cnt_r == 14'(IDLE_WINDOW_CYCLES - 1));

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            key_r <= 11'h0;
            match_cnt_r <= 6'h0;
            locked_r <= 1'b0;
        end else if (timeout) begin
            locked_r <= 1'b0;
            match_cnt_r <= 6'h0;
        end else if (s1_vld_r && !descr_bypass) begin
            // hunting on bypassed idles would lock onto an all-zero key
            if (locked_r) begin
                key_r <= {key_r[9:0], key_pred};
            end else begin
                key_r <= {key_r[9:0], ~nrzi_bit};
                if (~nrzi_bit == key_pred) begin
                    match_cnt_r <= match_cnt_r + 6'h1;
                    locked_r <= (match_cnt_r == `LOCK_MATCH_BITS);
                end else begin
                    match_cnt_r <= 6'h0;
                end
            end
        end
    end

    // the window restarts on every run of ten idle ones
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ones_cnt_r <= 4'h0;
            win_cnt_r <= 14'h0;
        end else begin
            if (plain_vld) begin
                ones_cnt_r <= plain ? ones_cnt_r + {3'h0, ones_cnt_r != `IDLE_RUN_BITS} : 4'h0;
            end
            if (!locked_r || timeout || ones_cnt_r == `IDLE_RUN_BITS) begin
                win_cnt_r <= 14'h0;
            end else begin
                win_cnt_r <= win_cnt_r + 14'h1;
            end
        end
    end

    // ****************************************************************
    // alignment and 5b/4b decoding
    // ****************************************************************
    function automatic logic [4:0] decode_cg(input logic [4:0] cg);
        case (cg)
            5'h1e: decode_cg = 5'h10;
            5'h09: decode_cg = 5'h11;
            5'h14: decode_cg = 5'h12;
            5'h15: decode_cg = 5'h13;
            5'h0a: decode_cg = 5'h14;
            5'h0b: decode_cg = 5'h15;
            5'h0e: decode_cg = 5'h16;
            5'h0f: decode_cg = 5'h17;
            5'h12: decode_cg = 5'h18;
            5'h13: decode_cg = 5'h19;
            5'h16: decode_cg = 5'h1a;
            5'h17: decode_cg = 5'h1b;
            5'h1a: decode_cg = 5'h1c;
            5'h1b: decode_cg = 5'h1d;
            5'h1c: decode_cg = 5'h1e;
            5'h1d: decode_cg = 5'h1f;
            default: decode_cg = 5'h00;
        endcase
    endfunction

    logic [9:0] win_r;
    logic [9:0] win_nxt;
    logic [2:0] bit_cnt_r;
    logic grp;
    logic [4:0] cg;
    logic [4:0] dec;
    logic [3:0] held_nib_r;
    logic held_er_r;
    logic held_b4_r;
    logic prev_idle_r;
    logic [3:0] nib_r;
    logic er_r;
    logic dv_r;
    logic crs_r;
    logic abort;

    assign win_nxt = {win_r[8:0], plain};
    assign grp = plain_vld && (bit_cnt_r == 3'h4);
    assign cg = win_nxt[4:0];
    assign dec = decode_cg(cg);
    assign abort = ~i_signal_present | i_link_fail | timeout;

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            win_r <= 10'h0;
            bit_cnt_r <= 3'h0;
        end else if (plain_vld) begin
            win_r <= win_nxt;
            if (state_r == ST_HUNT || bit_cnt_r == 3'h4) begin
                bit_cnt_r <= 3'h0;
            end else begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= ST_HUNT;
            held_nib_r <= 4'h0;
            held_er_r <= 1'b0;
            held_b4_r <= 1'b0;
            prev_idle_r <= 1'b0;
            nib_r <= 4'h0;
            er_r <= 1'b0;
            dv_r <= 1'b0;
            crs_r <= 1'b0;
        end else if (abort) begin
            state_r <= ST_HUNT;
            dv_r <= 1'b0;
            crs_r <= 1'b0;
            er_r <= 1'b0;
        end else begin
            case (state_r)
                ST_HUNT: begin
                    // a bad start flag stands until idles return, so it reaches the pins
                    if (plain_vld && win_nxt == {`CG_IDLE, `CG_IDLE}) begin
                        er_r <= 1'b0;
                    end
                    if (plain_vld && win_nxt == {`CG_IDLE, `CG_J}) begin
                        state_r <= ST_SSD;
                    end
                end
                ST_SSD: begin
                    if (grp && cg == `CG_K) begin
                        state_r <= ST_FRAME;
                        nib_r <= `NIB_PREAMBLE;
                        held_nib_r <= `NIB_PREAMBLE;
                        held_er_r <= 1'b0;
                        held_b4_r <= 1'b1;
                        er_r <= 1'b0;
                        dv_r <= 1'b1;
                        crs_r <= 1'b1;
                        prev_idle_r <= 1'b0;
                    end else if (grp) begin
                        state_r <= ST_HUNT;
                        nib_r <= `NIB_BAD_SSD;
                        er_r <= 1'b1;
                    end
                end
                ST_FRAME: begin
                    if (grp) begin
                        nib_r <= held_nib_r;
                        er_r <= dec_bypass ? held_b4_r : held_er_r;
                        prev_idle_r <= (cg == `CG_IDLE);
                        held_b4_r <= cg[4];
                        if (cg == `CG_IDLE && prev_idle_r) begin
                            state_r <= ST_HUNT;
                            dv_r <= 1'b0;
                            crs_r <= 1'b0;
                            er_r <= 1'b0;
                        end else if (cg == `CG_T) begin
                            state_r <= ST_END;
                        end else if (dec_bypass) begin
                            held_nib_r <= cg[3:0];
                        end else begin
                            held_nib_r <= dec[3:0];
                            held_er_r <= ~dec[4];
                        end
                    end
                end
                ST_END: begin
                    if (grp && cg == `CG_R) begin
                        state_r <= ST_HUNT;
                        dv_r <= 1'b0;
                        crs_r <= 1'b0;
                        er_r <= 1'b0;
                    end else if (grp) begin
                        state_r <= ST_FRAME;
                        er_r <= 1'b1;
                        held_er_r <= 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_HUNT;
                end
            endcase
        end
    end

    // ****************************************************************
    // MII / RMII launch
    // ****************************************************************
    logic [3:0] mii_cnt_r;
    logic [2:0] ref_cnt_r;
    logic half_r;
    logic [3:0] rmii_nib_r;

    // the MII clock follows code-group boundaries only while a signal is present and state_r is not ST_HUNT
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mii_cnt_r <= 4'h0;
            ref_cnt_r <= 3'h0;
            o_rx_clk <= 1'b0;
            o_ref_clk <= 1'b0;
        end else begin
            if (i_signal_present && grp && state_r != ST_HUNT) begin
                mii_cnt_r <= 4'h0;
            end else begin
                mii_cnt_r <= (mii_cnt_r == `MII_DIV - 4'h1) ? 4'h0 : mii_cnt_r + 4'h1;
            end
            ref_cnt_r <= (ref_cnt_r == `RMII_DIV - 3'h1) ? 3'h0 : ref_cnt_r + 3'h1;
            o_rx_clk <= ~rmii_mode_r && (mii_cnt_r < `MII_FALL - 4'h1 || mii_cnt_r == `MII_DIV - 4'h1);
            o_ref_clk <= rmii_mode_r && (ref_cnt_r < `RMII_FALL - 3'h1 || ref_cnt_r == `RMII_DIV - 3'h1);
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rxd <= 4'h0;
            o_rx_dv <= 1'b0;
            o_rx_er <= 1'b0;
            o_crs <= 1'b0;
            half_r <= 1'b0;
            rmii_nib_r <= 4'h0;
        end else if (!rmii_mode_r) begin
            if (mii_cnt_r == `MII_FALL - 4'h1) begin
                o_rxd <= nib_r;
                o_rx_dv <= dv_r;
                o_rx_er <= er_r;
                o_crs <= crs_r;
            end
        end else if (ref_cnt_r == `RMII_FALL - 3'h1) begin
            half_r <= ~half_r;
            if (!half_r) begin
                // status moves only with a low pair, so the mac sees whole nibbles
                o_rx_dv <= dv_r | crs_r;
                o_rx_er <= er_r;
                o_crs <= crs_r;
                rmii_nib_r <= nib_r;
                o_rxd <= {2'h0, nib_r[1:0]};
            end else begin
                o_rxd <= {2'h0, rmii_nib_r[3:2]};
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_ssd_bad;
        state_r == ST_SSD && grp && cg != `CG_K && !abort;
    endsequence
    sequence s_free_clk_high;
        o_rx_clk [*5] ##1 !o_rx_clk;
    endsequence

    AST_BAD_SSD: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        s_ssd_bad |=> er_r && nib_r == 4'he && !dv_r)
        else $error("bad start pair not flagged");
    AST_SSD_DV: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (state_r == ST_SSD && grp && cg == `CG_K && !abort) |=> dv_r && nib_r == 4'h5)
        else $error("data-valid missing on preamble");
    AST_ABORT_DV: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (!i_signal_present || i_link_fail) |=> !dv_r && !crs_r)
        else $error("data-valid held without signal");
    AST_ESD_END: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (state_r == ST_END && grp && cg == `CG_R && !abort) |=> !dv_r && state_r == ST_HUNT)
        else $error("end pair did not close frame");
    AST_RMII_NO_BYPASS: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        rmii_mode_r |-> !dec_bypass)
        else $error("decoder bypassed in RMII mode");
    AST_MII_LAUNCH: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (!rmii_mode_r && $changed(o_rxd)) |-> $past(mii_cnt_r) == 4'h4 && !o_rx_clk)
        else $error("MII nibble launched off the falling edge");
    AST_RMII_LAUNCH: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (rmii_mode_r && $changed(o_rxd)) |-> $past(ref_cnt_r) == 3'h2 && !o_ref_clk)
        else $error("RMII pair launched off the falling edge");
    AST_TIMEOUT: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        timeout |=> !locked_r && state_r == ST_HUNT && !dv_r)
        else $error("idle window expiry did not abort");
    AST_FREE_CLK: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (!rmii_mode_r && !i_signal_present && !$past(i_signal_present, 2) && $rose(o_rx_clk))
        |-> s_free_clk_high)
        else $error("free-running MII clock has wrong high time");
endmodule // fast_ethernet_rx_pcs
